// ---- src/dpdc_pkg.sv ----
package dpdc_pkg;
    // serial frame layout: 8-bit address then 8-bit data, msb first
    localparam int          FRAME_BITS      = 16;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam logic [7:0]  UNLOCK_ADDR     = 8'h11;
    localparam logic [7:0]  UNLOCK_KEY      = 8'h69;
    localparam logic [7:0]  PWR_CTRL_ADDR   = 8'h10;
    localparam int          DEEP_POWERDOWN_BIT_BIT_POS    = 0;
    localparam logic [7:0]  PWR_CTRL_RESET  = 8'h00;
    // power-up wait after the exit command
    localparam int          CLK_MHZ         = 20;
    localparam int          POWERUP_WAIT_NS = 1000;
    localparam int          POWERUP_CYCLES  = (POWERUP_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam int          WAIT_W          = 16;

    typedef enum logic [2:0] {
        DPDC_RUN   = 3'b001,
        DPDC_DOWN  = 3'b010,
        DPDC_WAKE  = 3'b100
    } dpdc_state_e;
endpackage

// ---- src/dpdc_deep_powerdown_control.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] - host writes key 69h to 11h first
// [RQ2] - set bit enters power-down at chip-select rise
// [RQ3] - power-down switches all analog circuitry off
// [RQ4] - registers and serial port stay alive
// [RQ5] - host clears the bit to exit
// [RQ6] - ready output rises after exit command
// [RQ7] - host waits power-up time before converting
// [RQ8] - host starts conversions with rising edge
// [RQ9] - only clearing the bit wakes device
module dpdc_deep_powerdown_control #(
    parameter int WAIT_CYCLES = dpdc_pkg::POWERUP_CYCLES
) (
    // clock, reset, enable
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // serial control port pins
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic sdi,
    // conversion start pin
    input  wire logic conversion_start,
    // power and status
    output logic      analog_enable,
    output logic      ready_output,
    output logic      deep_powerdown_state,
    output logic      powerup_done,
    output logic      conv_start_pulse
);
    import dpdc_pkg::*;

    // two-flop synchronisers for every pin
    logic [3:0] sync1_r, sync2_r, sync1_nxt, sync2_nxt;
    logic       sclk_d_r, cs_d_r, cv_d_r;
    logic       sclk_d_nxt, cs_d_nxt, cv_d_nxt;
    logic       cs_s, sclk_s, sdi_s, cv_s;
    logic       sclk_rise, cs_rise, cv_rise;

    // next values: pins into stage one, stage one into stage two, edge history
    always_comb begin
        sync1_nxt  = {conversion_start, sdi, sclk, cs_n};
        sync2_nxt  = sync1_r;
        sclk_d_nxt = sclk_s;
        cs_d_nxt   = cs_s;
        cv_d_nxt   = cv_s;
    end

    // pin sampling; stage one feeds stage two only
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_r  <= 4'h1;
            sync2_r  <= 4'h1;
            sclk_d_r <= 1'b0;
            cs_d_r   <= 1'b1;
            cv_d_r   <= 1'b0;
        end else if (clk_en) begin
            sync1_r  <= sync1_nxt;
            sync2_r  <= sync2_nxt;
            sclk_d_r <= sclk_d_nxt;
            cs_d_r   <= cs_d_nxt;
            cv_d_r   <= cv_d_nxt;
        end
    end

    assign cs_s      = sync2_r[0];
    assign sclk_s    = sync2_r[1];
    assign sdi_s     = sync2_r[2];
    assign cv_s      = sync2_r[3];
    assign sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
    assign cs_rise   = cs_s & ~cs_d_r;
    assign cv_rise   = cv_s & ~cv_d_r;

    // serial shifter and register writes
    logic [FRAME_BITS-1:0] shift_r, shift_nxt;
    logic [4:0]            bits_r, bits_nxt;
    logic                  unlock_r, unlock_nxt;
    logic [DATA_W-1:0]     pwr_ctrl_r, pwr_ctrl_nxt;
    logic                  frame_done;
    logic                  clear_cmd;

    assign frame_done = cs_rise && (bits_r == 5'(FRAME_BITS));
    assign clear_cmd  = frame_done && unlock_r
                        && shift_r[FRAME_BITS-1 -: ADDR_W] == PWR_CTRL_ADDR
                        && !shift_r[DEEP_POWERDOWN_BIT_BIT_POS] && pwr_ctrl_r[DEEP_POWERDOWN_BIT_BIT_POS];

    // the shifter keeps running in power-down so the host can reach it
    always_comb begin
        shift_nxt    = shift_r;
        bits_nxt     = bits_r;
        unlock_nxt   = unlock_r;
        pwr_ctrl_nxt = pwr_ctrl_r;
        if (sclk_rise) begin                                           // [RQ4]
            shift_nxt = {shift_r[FRAME_BITS-2:0], sdi_s};
            // counts on to 17 so an overlong frame is never taken
            if (bits_r <= 5'(FRAME_BITS))
                bits_nxt = bits_r + 5'h01;
        end
        if (cs_rise) begin
            bits_nxt = 5'h00;
            if (frame_done) begin
                if (shift_r[FRAME_BITS-1 -: ADDR_W] == UNLOCK_ADDR)
                    unlock_nxt = (shift_r[DATA_W-1:0] == UNLOCK_KEY);  // [RQ1]
                else if (shift_r[FRAME_BITS-1 -: ADDR_W] == PWR_CTRL_ADDR && unlock_r)
                    pwr_ctrl_nxt = shift_r[DATA_W-1:0];                // [RQ5]
            end
        end
    end

    // serial state registers; unlock and power register survive power-down
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_r    <= '0;
            bits_r     <= 5'h00;
            unlock_r   <= 1'b0;
            pwr_ctrl_r <= PWR_CTRL_RESET;
        end else if (clk_en) begin
            shift_r    <= shift_nxt;
            bits_r     <= bits_nxt;
            unlock_r   <= unlock_nxt;
            pwr_ctrl_r <= pwr_ctrl_nxt;
        end
    end

    // power state machine
    dpdc_state_e       state_r, state_nxt;
    logic [WAIT_W-1:0] wait_r, wait_nxt;
    logic              ready_r, ready_nxt;

    // entry takes effect at the cs rise that ends the setting write
    always_comb begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        ready_nxt = ready_r;
        case (state_r)
            DPDC_RUN: begin
                ready_nxt = 1'b1;
                if (cs_rise && pwr_ctrl_nxt[DEEP_POWERDOWN_BIT_BIT_POS]) begin       // [RQ2]
                    state_nxt = DPDC_DOWN;
                    ready_nxt = 1'b0;
                end
            end
            DPDC_DOWN: begin
                // cs rises other than the one ending a clearing write, and conversion_start activity, are ignored here
                if (clear_cmd) begin                                   // [RQ9]
                    state_nxt = DPDC_WAKE;
                    ready_nxt = 1'b1;                                  // [RQ6]
                    wait_nxt  = WAIT_W'(WAIT_CYCLES);
                end
            end
            DPDC_WAKE: begin
                if (wait_r != '0)
                    wait_nxt = wait_r - WAIT_W'(1);
                else
                    state_nxt = DPDC_RUN;
            end
            default: begin
                state_nxt = DPDC_RUN;
                ready_nxt = 1'b1;
            end
        endcase
    end

    // power state registers; reset comes up running with ready high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= DPDC_RUN;
            wait_r  <= '0;
            ready_r <= 1'b1;
        end else if (clk_en) begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            ready_r <= ready_nxt;
        end
    end

    // outputs
    assign analog_enable        = (state_r != DPDC_DOWN);              // [RQ3]
    assign deep_powerdown_state = (state_r == DPDC_DOWN);
    assign ready_output         = ready_r;
    assign powerup_done         = (state_r == DPDC_RUN);               // [RQ7]
    assign conv_start_pulse     = cv_rise && (state_r == DPDC_RUN);    // [RQ8]

    // assertions
    sequence seq_exit;
        state_r == DPDC_DOWN && clear_cmd && clk_en;
    endsequence

    sequence seq_wake_last;
        state_r == DPDC_WAKE && wait_r == '0 && clk_en;
    endsequence

    AST_ENTER_ON_CS: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
        (state_r == DPDC_RUN && cs_rise && pwr_ctrl_nxt[DEEP_POWERDOWN_BIT_BIT_POS] && clk_en)
        |=> deep_powerdown_state)
        else $error("power-down not entered at cs rise");

    AST_ANALOG_OFF: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
        deep_powerdown_state |-> !analog_enable)
        else $error("analog on during power-down");

    AST_REGS_KEPT: assert property (@(posedge clk) disable iff (sys_rst) // [RQ4]
        (deep_powerdown_state && !cs_rise) |=> $stable(pwr_ctrl_r))
        else $error("register changed without write");

    AST_READY_ON_EXIT: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
        seq_exit |=> ready_output && state_r == DPDC_WAKE)
        else $error("ready not raised after exit");

    AST_ONLY_BIT_WAKES: assert property (@(posedge clk) disable iff (sys_rst) // [RQ9]
        (deep_powerdown_state && !clear_cmd) |=> deep_powerdown_state)
        else $error("woke without clear command");

    AST_NO_CONV_IN_WAKE: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
        (state_r != DPDC_RUN) |-> !conv_start_pulse)
        else $error("conversion start passed before power-up");

    AST_READY_LOW_DOWN: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
        deep_powerdown_state |-> !ready_output)
        else $error("ready high during power-down");

    AST_WAKE_ENDS: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
        seq_wake_last |=> powerup_done && ready_output)
        else $error("power-up wait did not end in run");

    AST_LOCKED_NO_ENTRY: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
        (state_r == DPDC_RUN && !unlock_r && !pwr_ctrl_r[DEEP_POWERDOWN_BIT_BIT_POS] && clk_en)
        |=> !deep_powerdown_state)
        else $error("power-down entered while locked");
endmodule

// ---- dv/dpdc_host_model.sv ----
`timescale 1ns/1ps
module dpdc_host_model (
    // host pins, idle levels from time zero
    output logic cs_n = 1'b1,
    output logic sclk = 1'b0,
    output logic sdi  = 1'b0,
    output logic conv = 1'b0
);
    // addr byte then data byte, msb first; sclk stands low outside frames
    task automatic frame(input logic [15:0] w);
        #7 cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            #200 sclk = 1'b1;
            #200 sclk = 1'b0;
        end
        #200 cs_n = 1'b1;
        sdi = ~sdi; // released line shows no stale bit
    endtask
    // one rising edge per conversion request
    task automatic pulse();
        #7 conv = 1'b1;
        #300 conv = 1'b0;
        #293; // hand back at the bench's usual offset after a clock edge
    endtask
endmodule

// ---- dv/deep_powerdown_control_tb_top.sv ----
`timescale 1ns/1ps
module deep_powerdown_control_tb_top;
    import dpdc_pkg::*;
    localparam int WC = 4; // short power-up wait keeps the run brief
    logic        clk = 1'b0;
    logic        en = 1'b1;
    logic        sys_rst = 1'b1;
    logic        cs_n, sclk, sdi, conv, an, rdy, pd, done, pls;
    logic [31:0] rs = 32'h8;
    int          fail_count = 0, samples_checked = 0, np = 0;
    always #25 clk = ~clk;
    dpdc_host_model i_host (.cs_n(cs_n), .sclk(sclk), .sdi(sdi), .conv(conv));
    dpdc_deep_powerdown_control #(.WAIT_CYCLES(WC)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .clk_en(en), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .conversion_start(conv),
        .analog_enable(an), .ready_output(rdy), .deep_powerdown_state(pd),
        .powerup_done(done), .conv_start_pulse(pls));
    // pulse tally
    always @(posedge clk) np <= np + int'(pls);
    // hang guard in clock cycles
    initial begin
        repeat (6000) @(posedge clk);
        fail_count++;
        final_report();
    end
    function automatic logic [7:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs[7:0];
    endfunction
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic st(logic down);
        chk("pd", 8'(pd), 8'(down));
        chk("analog", 8'(an), 8'(!down));
        chk("ready", 8'(rdy), 8'(!down));
        chk("done", 8'(done), 8'(!down));
    endtask
    task automatic fr(logic [7:0] a, logic [7:0] d);
        i_host.frame({a, d});
        repeat (8) @(posedge clk); // synchronisers settle
        #2;
    endtask
    task automatic final_report();
        $display("checked %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // main sequence
    initial begin
        logic [7:0] d;
        int         n;
        repeat (6) @(posedge clk);
        #2 sys_rst = 1'b0;
        repeat (4) @(posedge clk);
        #2 st(1'b0);
        // wrong key: the set bit is refused, the next rise must not enter
        d = rnd();
        fr(UNLOCK_ADDR, d == UNLOCK_KEY ? 8'h00 : d);
        fr(PWR_CTRL_ADDR, 8'h01);
        fr(UNLOCK_ADDR, UNLOCK_KEY);
        st(1'b0);
        // the setting write's own rise enters; later rises keep it down
        fr(PWR_CTRL_ADDR, 8'h01);
        st(1'b1);
        fr(8'h00, d);
        st(1'b1);
        // other traffic and conversion starts keep it down
        n = np;
        repeat (4) begin
            d = rnd();
            fr(d[7:1] == 7'h08 ? 8'h22 : d, rnd());
            i_host.pulse();
        end
        st(1'b1);
        chk("pulse", 8'(np - n), 8'h00);
        // with the enable low even a clearing frame goes unseen
        en = 1'b0;
        i_host.frame({PWR_CTRL_ADDR, 8'h00});
        @(posedge clk);
        #2 en = 1'b1;
        repeat (8) @(posedge clk);
        #2 st(1'b1);
        // ready rises first, powerup_done follows after the wait
        i_host.frame({PWR_CTRL_ADDR, 8'h00});
        n = 0;
        while (done !== 1'b1 && n < 60) begin
            @(posedge clk);
            #2 n += int'(rdy === 1'b1);
        end
        chk("wait", 8'(n), 8'(WC + 2));
        st(1'b0);
        n = np;
        i_host.pulse();
        repeat (4) @(posedge clk);
        #2 chk("pulse", 8'(np - n), 8'h01);
        final_report();
    end
endmodule
